// *** src/wd_supervisor_pkg.sv ***
// Purpose: shared constants for the watchdog and supply supervisor
// Assumes: 10 MHz pclk, APB register access
// Notes:   offsets below are byte addresses, field positions are bit numbers
package wd_supervisor_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ        = 10000000;
   localparam int unsigned MS_CYC        = CLK_HZ / 1000;
   localparam int unsigned LONG_WIN_MS   = 200;
   localparam int unsigned RESET_DLY_MS  = 10;
   localparam int unsigned CLOSED_PCT    = 60;
   localparam int unsigned UV_FS_COUNT   = 4;
   // ==========================================================
   // register offsets
   localparam logic [11:0] OFS_WD_SET    = 12'h000;
   localparam logic [11:0] OFS_WATCHDOG_CONTROL_REGISTER   = 12'h004;
   localparam logic [11:0] OFS_WAKE_CTRL = 12'h008;
   localparam logic [11:0] OFS_MODE      = 12'h00c;
   localparam logic [11:0] OFS_SUPPLY    = 12'h010;
   localparam logic [11:0] OFS_STATUS    = 12'h014;
   // ==========================================================
   // watchdog_setting_register fields (bits 15..8 and reserved bit 3 of the write word)
   localparam int unsigned SET_CHK_BIT   = 15;
   localparam int unsigned SET_WIN_BIT   = 13;
   localparam int unsigned SET_PER_LSB   = 9;
   localparam int unsigned SET_RSVD_BIT  = 3;
   // watchdog_control_register / wake_control_register
   localparam int unsigned CTRL_STM1_BIT = 0;
   localparam int unsigned CTRL_OVR_BIT  = 1;
   localparam int unsigned CTRL_V3K_BIT  = 2;
   localparam int unsigned WAKE_STM0_BIT = 0;
   localparam int unsigned WAKE_BUS_BIT  = 1;
   // status flag positions (write one to clear)
   localparam int unsigned ST_POR  = 0;
   localparam int unsigned ST_BLOW = 1;
   localparam int unsigned ST_SLOW = 2;
   localparam int unsigned ST_SHI  = 3;
   localparam int unsigned ST_PW   = 4;
   localparam int unsigned ST_MLOW = 5;
   localparam int unsigned ST_RFS  = 6;
   localparam int unsigned ST_MHI  = 7;
   localparam int unsigned ST_SPIF = 8;
   localparam int unsigned ST_NUM  = 9;
   // ==========================================================
   // reset values, modes and mode commands
   localparam logic [2:0]  PER_RST       = 3'h1;
   localparam logic        BUS_START_RST = 1'b1;
   typedef enum logic [2:0] {
      M_INIT, M_NORMAL, M_STOP, M_RESTART, M_FAILSAFE
   } mode_t;
   localparam logic [1:0]  MODE_CMD_NORMAL = 2'h1;
   localparam logic [1:0]  MODE_CMD_STOP   = 2'h2;
endpackage

// *** src/wd_supervisor.sv ***
// Purpose: time-out / window watchdog with supply event handling
// Assumes: supply comparators and bus wake are asynchronous pins
// Notes:   mode commands arrive as APB writes to the mode register
`timescale 1ns/1ps
module wd_supervisor
   import wd_supervisor_pkg::*;
#(
   parameter int unsigned LONG_CYC  = LONG_WIN_MS * MS_CYC,
   parameter int unsigned RDLY_CYC  = RESET_DLY_MS * MS_CYC,
   parameter int unsigned MS_DIV    = MS_CYC
)
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // supply comparators and pins
   input  wire logic        battery_por_n,
   input  wire logic        battery_low,
   input  wire logic        switch_supply_low,
   input  wire logic        switch_supply_high,
   input  wire logic        main_regulator_prewarn,
   input  wire logic        main_regulator_low,
   input  wire logic        main_regulator_high,
   input  wire logic        restart_config_input,
   input  wire logic        can_wake,
   // outputs
   output logic             reset_output_pin_n,
   output logic             fail_outputs,
   output logic             third_regulator_en,
   output logic             sc_protect_en,
   output logic             wake_irq,
   output logic             can_rxd_low
);
   // ==========================================================
   // input synchronisers
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] sp_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         sp_q <= '0;
      end
      else
      begin
         s1_q <= {can_wake, restart_config_input, main_regulator_high, main_regulator_low,
                  main_regulator_prewarn, switch_supply_high, switch_supply_low,
                  battery_low, ~battery_por_n};
         s2_q <= s1_q;
         sp_q <= s2_q;
      end
   end
   wire por_s  = s2_q[0];
   wire blow_s = s2_q[1];
   wire mlow_s = s2_q[5];
   wire mhi_s  = s2_q[6];
   wire cfg_s  = s2_q[7];
   wire wake_e = s2_q[8] & ~sp_q[8];
   wire mlow_e = mlow_s & ~sp_q[5];
   wire mhi_e  = mhi_s & ~sp_q[6];

   // ==========================================================
   // apb decode: zero wait states
   wire wr = psel & penable & pwrite;
   wire rd = psel & ~penable & ~pwrite;
   wire hit_set  = (paddr == OFS_WD_SET);
   wire hit_ctrl = (paddr == OFS_WATCHDOG_CONTROL_REGISTER);
   wire hit_wake = (paddr == OFS_WAKE_CTRL);
   wire hit_mode = (paddr == OFS_MODE);
   wire hit_sup  = (paddr == OFS_SUPPLY);
   wire hit_st   = (paddr == OFS_STATUS);
   wire mapped   = hit_set | hit_ctrl | hit_wake | hit_mode | hit_sup | hit_st;
   mode_t mode_q;
   logic [2:0]  per_q;
   logic        win_q;
   logic        stm0_q;
   logic        stm1_q;
   logic        bus_start_q;
   logic        ovr_q;
   logic        v3keep_q;
   logic        wd_off_q;
   logic [ST_NUM-1:0] st_q;
   logic [2:0]  uvcnt_q;
   logic [1:0]  fail_cnt_q;

   wire [7:0] set_byte = pwdata[15:8];
   wire parity_ok = ~^{set_byte, pwdata[SET_RSVD_BIT]};
   wire normal = (mode_q == M_NORMAL);
   wire set_wr   = wr & hit_set & (normal | mode_q == M_STOP);
   wire service  = set_wr & parity_ok;
   wire bad_par  = set_wr & ~parity_ok;
   wire mode_wr  = wr & hit_mode;
   wire to_norm  = mode_wr & (pwdata[1:0] == MODE_CMD_NORMAL) & (mode_q == M_STOP);
   wire to_stop  = mode_wr & (pwdata[1:0] == MODE_CMD_STOP) & normal;

   // ==========================================================
   // watchdog period timer
   logic [31:0] cyc_q;
   logic        long_q;
   logic [31:0] per_cyc;
   always_comb
   begin
      case (per_q)
         3'h2:    per_cyc = 32'(MS_DIV) * 32'd20;
         3'h3:    per_cyc = 32'(MS_DIV) * 32'd50;
         3'h4:    per_cyc = 32'(MS_DIV) * 32'd100;
         3'h5:    per_cyc = 32'(MS_DIV) * 32'd200;
         3'h6:    per_cyc = 32'(MS_DIV) * 32'd500;
         3'h7:    per_cyc = 32'(MS_DIV) * 32'd1000;
         default: per_cyc = 32'(MS_DIV) * 32'd10;
      endcase
   end
   // open window centred on the nominal period: ends at 1.4x period
   wire [31:0] closed_cyc = 32'((64'(per_cyc) * CLOSED_PCT) / 100);
   wire [31:0] end_cyc    = long_q ? 32'(LONG_CYC)
                          : (win_q ? per_cyc + (per_cyc - closed_cyc) : per_cyc);
   wire wd_run   = ~wd_off_q & (normal | mode_q == M_STOP);
   wire expired  = wd_run & (cyc_q >= end_cyc - 32'd1);
   wire early    = service & win_q & ~long_q & (cyc_q < closed_cyc);
   wire service_failure_count  = expired | early;
   wire fail_tgt = cfg_s;
   wire wake_go  = wake_e & (mode_q == M_STOP) & bus_start_q & wd_off_q;
   wire ovr_go   = mhi_e & ovr_q & (mode_q != M_RESTART) & (mode_q != M_FAILSAFE);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cyc_q  <= '0;
         long_q <= 1'b1;
      end
      else if (!wd_run || service_failure_count)
      begin
         cyc_q  <= '0;
         long_q <= 1'b1;
      end
      else if (service || to_norm || wake_go)
      begin
         cyc_q  <= '0;
         long_q <= (mode_q == M_STOP) | to_norm;
      end
      else
         cyc_q <= cyc_q + 32'd1;
   end

   // ==========================================================
   // settings and stop-disable sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         per_q       <= PER_RST;
         win_q       <= 1'b0;
         stm0_q      <= 1'b0;
         stm1_q      <= 1'b0;
         bus_start_q <= BUS_START_RST;
         ovr_q       <= 1'b0;
         v3keep_q    <= 1'b0;
         wd_off_q    <= 1'b0;
      end
      else if (por_s)
      begin
         per_q       <= PER_RST;
         win_q       <= 1'b0;
         stm0_q      <= 1'b0;
         stm1_q      <= 1'b0;
         bus_start_q <= BUS_START_RST;
         ovr_q       <= 1'b0;
         v3keep_q    <= 1'b0;
         wd_off_q    <= 1'b0;
      end
      else
      begin
         if (service && normal)
         begin
            per_q <= set_byte[SET_PER_LSB-8 +: 3];
            win_q <= set_byte[SET_WIN_BIT-8];
         end
         if (wr && hit_wake && normal)
         begin
            // starting the sequence again drops a stale first bit
            stm0_q      <= pwdata[WAKE_STM0_BIT] & ~stm0_q;
            bus_start_q <= pwdata[WAKE_BUS_BIT];
         end
         if (wr && hit_ctrl && normal)
         begin
            stm1_q   <= pwdata[CTRL_STM1_BIT] & stm0_q;
            ovr_q    <= pwdata[CTRL_OVR_BIT];
            v3keep_q <= pwdata[CTRL_V3K_BIT];
         end
         if (to_stop)
            wd_off_q <= stm0_q & stm1_q;
         if ((service && mode_q == M_STOP) || to_norm || wake_go)
         begin
            wd_off_q <= 1'b0;
            stm0_q   <= 1'b0;
            stm1_q   <= 1'b0;
         end
         if (ovr_go && fail_tgt)
            ovr_q <= 1'b0;
      end
   end

   // ==========================================================
   // mode control and reset output
   wire uv_hit = mlow_e & (mode_q == M_INIT | normal | mode_q == M_STOP)
                 & ~(normal & blow_s);
   wire uv_fs  = uv_hit & (uvcnt_q == 3'(UV_FS_COUNT - 1));
   logic [31:0] rd_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= M_INIT;
         rd_q   <= '0;
      end
      else if (por_s)
      begin
         mode_q <= M_INIT;
         rd_q   <= '0;
      end
      else if (uv_fs)
         mode_q <= M_FAILSAFE;
      else if (mlow_s)
      begin
         mode_q <= (mode_q == M_FAILSAFE) ? M_FAILSAFE : M_RESTART;
         rd_q   <= '0;
      end
      else if (service_failure_count || ovr_go)
      begin
         mode_q <= fail_tgt ? M_RESTART : M_FAILSAFE;
         rd_q   <= '0;
      end
      else
         case (mode_q)
            M_INIT, M_RESTART:
               if (rd_q >= 32'(RDLY_CYC) - 32'd1)
                  mode_q <= M_NORMAL;
               else
                  rd_q <= rd_q + 32'd1;
            M_NORMAL:
               if (to_stop)
                  mode_q <= M_STOP;
            M_STOP:
               if (to_norm)
                  mode_q <= M_NORMAL;
            default: mode_q <= mode_q;
         endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_output_pin_n <= 1'b0;
         fail_outputs       <= 1'b0;
      end
      else
      begin
         reset_output_pin_n <= (mode_q == M_NORMAL) | (mode_q == M_STOP);
         fail_outputs <= ~por_s & (fail_outputs | ovr_go | mode_q == M_FAILSAFE);
      end
   end

   // ==========================================================
   // undervoltage counter and failure count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         uvcnt_q <= '0;
      else if (por_s || mode_q == M_FAILSAFE || uv_fs
               || (wr && hit_st && pwdata[ST_MLOW]))
         uvcnt_q <= '0;
      else if (uv_hit)
         uvcnt_q <= uvcnt_q + 3'd1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fail_cnt_q <= '0;
      else if (service_failure_count && fail_cnt_q != 2'h3)
         fail_cnt_q <= fail_cnt_q + 2'd1;
      else if (service || wd_off_q)
         fail_cnt_q <= '0;
   end

   // ==========================================================
   // sticky status flags: set wins over clear
   logic [ST_NUM-1:0] st_set;
   always_comb
   begin
      st_set[ST_POR]  = por_s;
      st_set[ST_BLOW] = blow_s;
      st_set[ST_SLOW] = s2_q[2];
      st_set[ST_SHI]  = s2_q[3];
      st_set[ST_PW]   = s2_q[4];
      st_set[ST_MLOW] = mlow_s;
      st_set[ST_RFS]  = uv_fs;
      st_set[ST_MHI]  = mhi_s & (mode_q == M_INIT | normal | mode_q == M_STOP);
      st_set[ST_SPIF] = bad_par;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= 9'h001;
      else if (por_s)
         st_q <= st_set;
      else if (wr && hit_st)
         st_q <= (st_q & ~pwdata[ST_NUM-1:0]) | st_set;
      else
         st_q <= st_q | st_set;
   end

   // ==========================================================
   // supply-driven outputs and wake indication
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         third_regulator_en <= 1'b0;
         sc_protect_en      <= 1'b0;
         wake_irq           <= 1'b0;
         can_rxd_low        <= 1'b0;
      end
      else
      begin
         third_regulator_en <= ~blow_s | v3keep_q;
         sc_protect_en      <= ~blow_s;
         wake_irq           <= wake_e & (mode_q == M_STOP);
         can_rxd_low        <= (mode_q == M_STOP) & (can_rxd_low | wake_e);
      end
   end

   // ==========================================================
   // apb read path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (rd)
         begin
            if (hit_set)
               prdata <= {16'h0, 2'b00, win_q, 1'b0, per_q, 9'h000}; // bit 3 reads 0
            else if (hit_ctrl)
               prdata <= {29'h0, v3keep_q, ovr_q, stm1_q};
            else if (hit_wake)
               prdata <= {30'h0, bus_start_q, stm0_q};
            else if (hit_mode)
               prdata <= {25'h0, fail_cnt_q, wd_off_q, long_q, mode_q};
            else if (hit_sup)
               prdata <= {29'h0, uvcnt_q};
            else if (hit_st)
               prdata <= {23'h0, st_q};
            else
               prdata <= '0;
         end
      end
   end
endmodule

// *** bench/wd_supervisor_asserts.sv ***
// Purpose: port-level checks of the watchdog supervisor
// Assumes: supply inputs pass a two-flop synchroniser
// Notes:   bound to the design from tb_top
`timescale 1ns/1ps
module wd_supervisor_asserts
   import wd_supervisor_pkg::*;
#(
   parameter int unsigned RDLY_CYC = 20
)
(
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // supplies and pins
   input wire logic        battery_por_n,
   input wire logic        battery_low,
   input wire logic        main_regulator_low,
   input wire logic        reset_output_pin_n,
   input wire logic        fail_outputs,
   input wire logic        sc_protect_en,
   input wire logic        wake_irq
);
   // ==========================================
   // helpers
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] low_q;
   logic [2:0]  por_q;
   // low time of the pin, so each release can be tied to the delay
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         low_q <= 16'h0000;
      else
         low_q <= reset_output_pin_n ? 16'h0000 : low_q + 16'h0001;
   // a power-on event ends the fail outputs, so wait until it is long gone
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         por_q <= 3'h0;
      else
         por_q <= !battery_por_n ? 3'h0 : (por_q == 3'h7 ? por_q : por_q + 3'h1);
   // ==========================================
   // properties
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_slverr;
      psel && !penable && paddr > OFS_STATUS |=> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_low_rst;
      $rose(main_regulator_low) |-> ##[1:5] !reset_output_pin_n;
   endproperty
   a_low_rst: assert property (p_low_rst) else $error("undervoltage left reset high");
   property p_sc_off;
      battery_low [*4] |-> !sc_protect_en;
   endproperty
   a_sc_off: assert property (p_sc_off) else $error("protection kept in battery low");
   property p_irq_pulse;
      wake_irq |=> !wake_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("wake pulse too long");
   property p_rst_hold;
      $fell(reset_output_pin_n) |=> !reset_output_pin_n [*8];
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset pulse too short");
   property p_release;
      $rose(reset_output_pin_n) |-> low_q >= RDLY_CYC - 1;
   endproperty
   a_release: assert property (p_release) else $error("reset released early");
   property p_fail_hold;
      fail_outputs && por_q == 3'h7 |=> fail_outputs;
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("fail outputs dropped");
endmodule

// *** bench/host_model.sv ***
// Purpose: host side that reaches the supervisor registers
// Assumes: any number of wait states, single words
// Notes:   signals move only right after a rising edge
`timescale 1ns/1ps
module host_model
   import wd_supervisor_pkg::*;
(
   // apb master
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // ==========================================
   // request held until ready is seen at a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // reserved bit 3 counts too; bad inverts the checksum on purpose
   function automatic logic [31:0] set_word(input logic win, input logic [2:0] per,
                                            input logic rsv, input logic bad);
      logic [31:0] d;
      d = 32'h0000_0000;
      d[SET_WIN_BIT] = win;
      d[SET_PER_LSB +: 3] = per;
      d[SET_RSVD_BIT] = rsv;
      d[SET_CHK_BIT] = ^{d[14:8], d[SET_RSVD_BIT]} ^ bad;
      return d;
   endfunction
endmodule

// *** bench/tb_top.sv ***
// Purpose: directed bench for the watchdog supply supervisor
// Assumes: shortened counts, one millisecond is ten cycles
// Notes:   every register access goes through host_model
`timescale 1ns/1ps
module tb_top
   import wd_supervisor_pkg::*;
;
   localparam int unsigned LONG = 200;
   localparam int unsigned RDLY = 20;
   localparam int unsigned PER  = 100;
   logic        pclk, presetn, psel, penable, pwrite, pready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        battery_por_n, battery_low, sw_low, sw_high, prewarn, mlow, mhigh, cfg;
   logic        can_wake, pin_n, fail_o, v3_en, sc_en, wake_irq, rxd_low, t3;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          lows = 0;
   int          n, mark;
   wd_supervisor #(.LONG_CYC(LONG), .RDLY_CYC(RDLY), .MS_DIV(10)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .battery_por_n(battery_por_n), .battery_low(battery_low), .switch_supply_low(sw_low),
      .switch_supply_high(sw_high), .main_regulator_prewarn(prewarn),
      .main_regulator_low(mlow), .main_regulator_high(mhigh), .restart_config_input(cfg),
      .can_wake(can_wake), .reset_output_pin_n(pin_n), .fail_outputs(fail_o),
      .third_regulator_en(v3_en), .sc_protect_en(sc_en), .wake_irq(wake_irq),
      .can_rxd_low(rxd_low));
   host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   always @(negedge pclk)
      if (pin_n === 1'b0)
         lows <= lows + 1;
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         $display("Error at %0t: timeout", $time);
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   // ==========================================
   // tasks
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic ok(input logic c, input string m);
      comparisons = comparisons + 1;
      if (c !== 1'b1)
      begin
         bad_count = bad_count + 1;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string s);
      host.xfer(1'b0, a, 32'h0000_0000, q);
      ok((q & m) === e, s);
   endtask
   // cycles until the pin shows lvl, looked at mid-cycle where it has settled
   task automatic wait_pin(input logic lvl, input int max);
      n = 0;
      while (pin_n !== lvl && n < max)
      begin
         @(negedge pclk);
         n = n + 1;
      end
   endtask
   task automatic serve(input logic win);
      wr(OFS_WD_SET, host.set_word(win, 3'h1, 1'b1, 1'b0));
   endtask
   // ==========================================
   // tests
   initial
   begin
      presetn = 1'b0;
      battery_por_n = 1'b1;
      {battery_low, sw_low, sw_high, prewarn, mlow, mhigh, can_wake} = 7'h00;
      cfg = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wait_pin(1'b1, 60);
      ok(n >= RDLY - 2, "release before delay");
      rd(OFS_STATUS, 32'h1, 32'h1, "power-on flag");
      rd(OFS_WAKE_CTRL, 32'h2, 32'h2, "bus wake default");
      rd(12'h020, 32'hffff_ffff, 32'h0, "unmapped read");
      $display("test power-on done");
      t3 = v3_en;
      @(posedge pclk) {sw_low, sw_high, prewarn} <= 3'h7;
      repeat (6) @(posedge pclk);
      ok(pin_n === 1'b1 && v3_en === t3 && sc_en === 1'b1, "flag-only event acted");
      rd(OFS_STATUS, 32'h1c, 32'h1c, "switch or prewarn flag");
      @(posedge pclk) {sw_low, sw_high, prewarn} <= 3'h0;
      repeat (4) @(posedge pclk);
      wr(OFS_STATUS, 32'hffff_ffff);
      rd(OFS_STATUS, 32'h1c, 32'h0, "flags not cleared");
      @(posedge pclk) battery_low <= 1'b1;
      repeat (6) @(posedge pclk);
      ok(v3_en === 1'b0 && sc_en === 1'b0, "battery low kept loads");
      rd(OFS_STATUS, 32'h3e, 32'h2, "battery flag not alone");
      @(posedge pclk) battery_low <= 1'b0;
      repeat (6) @(posedge pclk);
      ok(v3_en === t3 && sc_en === 1'b1, "no recovery");
      $display("test supplies done");
      wr(OFS_STATUS, 32'hffff_ffff);
      wr(OFS_WD_SET, host.set_word(1'b1, 3'h1, 1'b1, 1'b1));
      rd(OFS_STATUS, 32'h100, 32'h100, "parity flag");
      rd(OFS_WD_SET, 32'h2000, 32'h0, "bad write applied");
      serve(1'b0);
      rd(OFS_WD_SET, 32'h0e08, 32'h0200, "setting readback");
      mark = lows;
      repeat (3)
      begin
         repeat (80) @(posedge pclk);
         serve(1'b0);
      end
      ok(lows == mark, "reset while served");
      wait_pin(1'b0, 200);
      ok(n >= PER - 4 && n <= PER + 8, "time-out length");
      wait_pin(1'b1, 60);
      ok(n < 60, "no restart");
      wait_pin(1'b0, 400);
      ok(n >= LONG - 4 && n <= LONG + 30, "long window");
      wait_pin(1'b1, 60);
      $display("test time-out done");
      serve(1'b1);
      mark = lows;
      repeat (72) @(posedge pclk);
      serve(1'b1);
      repeat (114) @(posedge pclk);
      serve(1'b1);
      ok(lows == mark, "open window refused");
      repeat (30) @(posedge pclk);
      serve(1'b1);
      wait_pin(1'b0, 10);
      ok(n < 8, "closed window accepted");
      wait_pin(1'b1, 60);
      $display("test window done");
      wr(OFS_WAKE_CTRL, 32'h0000_0003);
      wr(OFS_WATCHDOG_CONTROL_REGISTER, 32'h0000_0001);
      wr(OFS_MODE, {30'h0, MODE_CMD_STOP});
      rd(OFS_MODE, 32'h10, 32'h10, "watchdog not disabled");
      repeat (5) @(posedge pclk);
      @(posedge pclk) can_wake <= 1'b1;
      n = 0;
      while (wake_irq !== 1'b1 && n < 10)
      begin
         @(negedge pclk);
         n = n + 1;
      end
      ok(n < 10 && rxd_low === 1'b1, "bus wake not signalled");
      rd(OFS_MODE, 32'h18, 32'h08, "bus wake did not start watchdog");
      rd(OFS_WATCHDOG_CONTROL_REGISTER, 32'h1, 32'h0, "second disable bit kept on wake");
      @(posedge pclk) can_wake <= 1'b0;
      wr(OFS_MODE, {30'h0, MODE_CMD_NORMAL});
      wait_pin(1'b0, 400);
      ok(n >= LONG - 4 && n <= LONG + 30, "no long window on return");
      wait_pin(1'b1, 60);
      wr(OFS_WAKE_CTRL, 32'h0000_0003);
      wr(OFS_WAKE_CTRL, 32'h0000_0003);
      rd(OFS_WAKE_CTRL, 32'h1, 32'h0, "first bit not dropped");
      wr(OFS_WATCHDOG_CONTROL_REGISTER, 32'h0000_0001);
      rd(OFS_WATCHDOG_CONTROL_REGISTER, 32'h1, 32'h0, "second bit out of order");
      $display("test stop done");
      wr(OFS_WATCHDOG_CONTROL_REGISTER, 32'h2);
      @(posedge pclk) mhigh <= 1'b1;
      wait_pin(1'b0, 10);
      ok(n < 8, "overvoltage kept reset high");
      wait_pin(1'b1, 60);
      ok(n < 60 && fail_o === 1'b1, "no resume or fail outputs");
      rd(OFS_WATCHDOG_CONTROL_REGISTER, 32'h2, 32'h0, "reset bit kept");
      rd(OFS_STATUS, 32'h80, 32'h80, "overvoltage flag");
      @(posedge pclk) mhigh <= 1'b0;
      $display("test overvoltage done");
      wr(OFS_STATUS, 32'hffff_ffff);
      repeat (4)
      begin
         @(posedge pclk) mlow <= 1'b1;
         wait_pin(1'b0, 10);
         ok(n < 8, "undervoltage kept reset high");
         @(posedge pclk) mlow <= 1'b0;
         wait_pin(1'b1, 60);
      end
      ok(pin_n === 1'b0, "no fail-safe on fourth event");
      rd(OFS_STATUS, 32'h60, 32'h60, "undervoltage flags");
      $display("test undervoltage done");
      @(posedge pclk) battery_por_n <= 1'b0;
      repeat (5) @(posedge pclk);
      battery_por_n <= 1'b1;
      wait_pin(1'b1, 60);
      ok(n < 60 && fail_o === 1'b0, "no restart after supply loss");
      rd(OFS_STATUS, 32'h61, 32'h1, "power-on defaults");
      $display("test power cycle done");
      tally_and_finish;
   end
endmodule

bind wd_supervisor wd_supervisor_asserts #(.RDLY_CYC(RDLY_CYC)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .battery_por_n(battery_por_n),
   .battery_low(battery_low), .main_regulator_low(main_regulator_low),
   .reset_output_pin_n(reset_output_pin_n), .fail_outputs(fail_outputs),
   .sc_protect_en(sc_protect_en), .wake_irq(wake_irq));
